// File: scsc_top.sv
/*
  System clock source control: one 8-bit control register that enables the
  oscillators, their failure detection, and selects the system clock source.
  Assumes software on a plain port: one-cycle strobes, read data next cycle.
*/
// How it works
// - Bit 7 turns the internal precision oscillator on when 1 and off when 0.
// - Bit 6 is reserved, written as 0 by software and always read back as 0.
// - Bit 5 turns the watchdog oscillator on when 1 and off when 0.
// - Bit 3 enables watchdog oscillator failure detection when 1.
// - Source code 000 selects the internal precision oscillator, fast setting.
// - Source code 001 selects the internal precision oscillator, slow setting.
// - Source code 011 selects the watchdog oscillator as system clock.
// - Source code 100 selects the external clock pin; 010 and 101 to 111 are reserved.
`default_nettype none
module scsc_top
  import scsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Oscillator controls
  output scsc_osc_ctl_t osc_ctl,
  // Source selects, one-hot; all low on a reserved code
  output scsc_sel_t src_sel,
  output logic [2:0] system_clock_source_field
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_nxt;
  // Only the one offset decodes; neighbours read as zero
  wire hit = (reg_addr == SCSC_CTRL_OFFSET);
  wire wr_hit = reg_wr && hit;
  scsc_sel_t sel_nxt;

  // Reserved source codes are stored as written, only the decode refuses them
  // reserved bit forced zero
  assign ctrl_nxt = wr_hit ? (reg_wdata & SCSC_CTRL_WMASK) : ctrl_r;
  // Unmapped reads return zero
  assign rdata_nxt = (reg_rd && hit) ? ctrl_r : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= SCSC_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Read data cleared each cycle so a stale value never lingers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs registered from the next value so they track the register
  // Limitation: no guard against picking a stopped oscillator; software owns that
  scsc_src_decode scsc_src_decode_i (
    .system_clock_source_field(ctrl_nxt[SCSC_SRC_MSB:0]),
    .sel(sel_nxt)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_ctl <= {SCSC_CTRL_RESET[SCSC_PREC_ON_BIT], SCSC_CTRL_RESET[SCSC_WDOG_ON_BIT],
        SCSC_CTRL_RESET[SCSC_PFAIL_BIT], SCSC_CTRL_RESET[SCSC_WFAIL_BIT]};
      src_sel <= 4'b1000;
      system_clock_source_field <= SCSC_CTRL_RESET[SCSC_SRC_MSB:0];
    end else begin
      osc_ctl.precision_osc_on <= ctrl_nxt[SCSC_PREC_ON_BIT];
      osc_ctl.watchdog_osc_on <= ctrl_nxt[SCSC_WDOG_ON_BIT];
      osc_ctl.primary_osc_fail_detect_on <= ctrl_nxt[SCSC_PFAIL_BIT];
      osc_ctl.watchdog_osc_fail_detect_on <= ctrl_nxt[SCSC_WFAIL_BIT];
      src_sel <= sel_nxt;
      system_clock_source_field <= ctrl_nxt[SCSC_SRC_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (!rst_n) reg_rdata[SCSC_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

  sequence s_write;
    reg_wr && hit;
  endsequence

  sequence s_read;
    reg_rd && hit;
  endsequence

  property p_prec;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> osc_ctl.precision_osc_on == $past(reg_wdata[SCSC_PREC_ON_BIT]);
  endproperty
  a_prec: assert property (p_prec) else $error("precision enable wrong");

  property p_wdog;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> osc_ctl.watchdog_osc_on == $past(reg_wdata[SCSC_WDOG_ON_BIT]);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");

  property p_pfail;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> osc_ctl.primary_osc_fail_detect_on == $past(reg_wdata[SCSC_PFAIL_BIT]);
  endproperty
  a_pfail: assert property (p_pfail) else $error("primary fail detect wrong");

  property p_wfail;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> osc_ctl.watchdog_osc_fail_detect_on == $past(reg_wdata[SCSC_WFAIL_BIT]);
  endproperty
  a_wfail: assert property (p_wfail) else $error("watchdog fail detect wrong");

  property p_fast;
    @(posedge ref_clk) disable iff (!rst_n)
      src_sel.sel_fast == (system_clock_source_field == SCSC_SRC_FAST);
  endproperty
  a_fast: assert property (p_fast) else $error("fast select wrong");

  property p_slow;
    @(posedge ref_clk) disable iff (!rst_n)
      src_sel.sel_slow == (system_clock_source_field == SCSC_SRC_SLOW);
  endproperty
  a_slow: assert property (p_slow) else $error("slow select wrong");

  property p_wsel;
    @(posedge ref_clk) disable iff (!rst_n)
      src_sel.sel_wdog == (system_clock_source_field == SCSC_SRC_WDOG);
  endproperty
  a_wsel: assert property (p_wsel) else $error("watchdog select wrong");

  property p_ext;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write ##1 1'b1 |-> src_sel.sel_ext == ($past(reg_wdata[SCSC_SRC_MSB:0]) == SCSC_SRC_EXT);
  endproperty
  a_ext: assert property (p_ext) else $error("external select wrong");

  property p_readback;
    @(posedge ref_clk) disable iff (!rst_n)
      s_read |=> reg_rdata == {$past(osc_ctl.precision_osc_on), 1'b0,
        $past(osc_ctl.watchdog_osc_on), $past(osc_ctl.primary_osc_fail_detect_on),
        $past(osc_ctl.watchdog_osc_fail_detect_on), $past(system_clock_source_field)};
  endproperty
  a_readback: assert property (p_readback) else $error("read back mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // defaults out of reset
  property p_rst_vals;
    @(posedge ref_clk)
      !rst_n |=> ctrl_r == SCSC_CTRL_RESET && reg_rdata == 8'h00 && osc_ctl == 4'b1100 &&
        src_sel == 4'b1000 && system_clock_source_field == 3'b000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");

  property p_ctrl_mask;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> ctrl_r == {$past(reg_wdata[SCSC_PREC_ON_BIT]), 1'b0, $past(reg_wdata[SCSC_WDOG_ON_BIT:0])};
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("stored value wrong");

  // enables move only on a write
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !wr_hit |=> $stable(osc_ctl) && $stable(system_clock_source_field);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed without a write");

  property p_field;
    @(posedge ref_clk) disable iff (!rst_n)
      s_write |=> system_clock_source_field == $past(reg_wdata[SCSC_SRC_MSB:0]);
  endproperty
  a_field: assert property (p_field) else $error("source field wrong");

  sequence s_rsvd_code;
    system_clock_source_field == SCSC_SRC_RSV2 || system_clock_source_field > SCSC_SRC_EXT;
  endsequence

  property p_rsvd_code;
    @(posedge ref_clk) disable iff (!rst_n)
      s_rsvd_code |-> src_sel == 4'b0000;
  endproperty
  a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code selected a source");

  // at most one source at a time
  property p_onehot;
    @(posedge ref_clk) disable iff (!rst_n)
      $onehot0(src_sel);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one source selected");

  // read data stand one cycle only
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !(reg_rd && hit) |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// File: scsc_pkg.sv
/*
  Package for the system clock source control block: register offset,
  field positions, reset value and clock source codes.
  Assumes one 8-bit register reached over a plain address/strobe port.
*/
`default_nettype none
package scsc_pkg;
  localparam logic [11:0] SCSC_CTRL_OFFSET = 12'hf86;
  localparam int SCSC_PREC_ON_BIT = 7;
  localparam int SCSC_RSVD_BIT = 6;
  localparam int SCSC_WDOG_ON_BIT = 5;
  localparam int SCSC_PFAIL_BIT = 4;
  localparam int SCSC_WFAIL_BIT = 3;
  localparam int SCSC_SRC_MSB = 2;
  localparam logic [7:0] SCSC_CTRL_RESET = 8'ha0;
  localparam logic [7:0] SCSC_CTRL_WMASK = 8'hbf;

  typedef enum logic [2:0] {
    SCSC_SRC_FAST = 3'b000,
    SCSC_SRC_SLOW = 3'b001,
    SCSC_SRC_RSV2 = 3'b010,
    SCSC_SRC_WDOG = 3'b011,
    SCSC_SRC_EXT = 3'b100
  } scsc_src_t;

  typedef struct packed {
    logic precision_osc_on;
    logic watchdog_osc_on;
    logic primary_osc_fail_detect_on;
    logic watchdog_osc_fail_detect_on;
  } scsc_osc_ctl_t;

  typedef struct packed {
    logic sel_fast;
    logic sel_slow;
    logic sel_wdog;
    logic sel_ext;
  } scsc_sel_t;
endpackage
`default_nettype wire

// File: scsc_src_decode.sv
/*
  Decodes the clock source field into one-hot selects.
  Assumes the field comes from the next value of the control register.
*/
`default_nettype none
module scsc_src_decode
  import scsc_pkg::*;
(
  // Field in
  input wire logic [2:0] system_clock_source_field,
  // Selects out
  output scsc_sel_t sel
);
  assign sel.sel_fast = (system_clock_source_field == SCSC_SRC_FAST);
  assign sel.sel_slow = (system_clock_source_field == SCSC_SRC_SLOW);
  assign sel.sel_wdog = (system_clock_source_field == SCSC_SRC_WDOG);
  assign sel.sel_ext = (system_clock_source_field == SCSC_SRC_EXT);
endmodule
`default_nettype wire

// File: tb_scsc_top.sv
/*
  Testbench for scsc_top: table of register writes, then reset,
  unmapped-address and read-timing cases.
  Assumes scsc_pkg is compiled first; the bench is the only bus master.
*/
`default_nettype none
module tb_scsc_top
  import scsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  scsc_osc_ctl_t osc_ctl;
  scsc_sel_t src_sel;
  logic [2:0] system_clock_source_field;
  int error_cnt = 0;
  int checks_done = 0;
  // Row: write data, read back, oscillator controls, selects
  // software keeps bit 6 at 0
  logic [23:0] rows [8] = '{24'h84_84_8_1, 24'h29_29_5_4, 24'h3b_3b_7_2, 24'h90_90_a_8,
    24'h02_02_0_0, 24'h05_05_0_0, 24'h06_06_0_0, 24'h07_07_0_0};

  scsc_top scsc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_ctl(osc_ctl), .src_sel(src_sel),
    .system_clock_source_field(system_clock_source_field));

  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, then drop to 0
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
    #1 chk("rdata_after", 8'h00, reg_rdata);
  endtask

  task automatic chk_out(input logic [7:0] o, input logic [7:0] s, input logic [7:0] f);
    chk("osc_ctl", o, {4'h0, osc_ctl});
    chk("src_sel", s, {4'h0, src_sel});
    chk("field", f, {5'h00, system_clock_source_field});
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk_out(8'h0c, 8'h08, 8'h00);
    rd(SCSC_CTRL_OFFSET, d);
    chk("reset_read", 8'ha0, d);
    foreach (rows[i]) begin
      wr(SCSC_CTRL_OFFSET, rows[i][23:16]);
      #1 chk_out({4'h0, rows[i][7:4]}, {4'h0, rows[i][3:0]}, {5'h00, rows[i][18:16]});
      rd(SCSC_CTRL_OFFSET, d);
      chk("ctrl_read", rows[i][15:8], d);
    end
    // Unmapped neighbours: writes ignored, upper neighbour reads zero
    wr(12'hf85, 8'hff);
    wr(12'hf87, 8'h84);
    #1 chk_out(8'h00, 8'h00, 8'h07);
    rd(12'hf87, d);
    chk("unmapped_read", 8'h00, d);
    rd(SCSC_CTRL_OFFSET, d);
    chk("ctrl_kept", 8'h07, d);
    // Second reset in mid-run
    wr(SCSC_CTRL_OFFSET, 8'h1c);
    #1 chk_out(8'h03, 8'h01, 8'h04);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1 chk_out(8'h0c, 8'h08, 8'h00);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(SCSC_CTRL_OFFSET, d);
    chk("rereset_read", 8'ha0, d);
    print_verdict();
  end
endmodule
`default_nettype wire
